/* rgc_dev_model.sv */
// Behavioural model of the receiver's serial port, gains and readback.
// Assumes MSB-first words latched on the rising load strobe.
`timescale 1ns/10ps
module rgc_dev_model (
   input  wire logic       ser_clk,
   input  wire logic       ser_data,
   input  wire logic       ser_load,
   input  wire logic [6:0] level,
   output logic            ser_read_data,
   output logic [31:0]     word
);
   logic [31:0] shift_reg = 32'h0;
   logic [15:0] rb_reg    = 16'h0;
   logic [1:0]  lna_reg   = 2'h3;
   logic [1:0]  filt_reg  = 2'h2;
   assign ser_read_data = rb_reg[15];
   always @(posedge ser_clk)
      shift_reg <= {shift_reg[30:0], ser_data};
   always @(posedge ser_load or negedge ser_clk)
      if (ser_load)
      begin
         word <= shift_reg;
         rb_reg <= {4'h0, lna_reg, filt_reg, level, 1'b0};
         if (shift_reg[3:0] == rgc_pkg::DEV_ADDR_GAIN && shift_reg[19])
         begin
            lna_reg <= shift_reg[21:20];
            filt_reg <= shift_reg[23:22];
         end
      end
      else
         rb_reg <= {rb_reg[14:0], ~rb_reg[15]};   // Released line keeps toggling
endmodule : rgc_dev_model

/* rgc_host.sv */
// Host controller: APB registers, device serial port driver, level
// conversion and setting calculations.
// Assumes the device latches a 32-bit word on the load strobe and
// returns 16 readback bits clocked out after it.
//
// Notes on behaviour
// [R1] Device digitises signal level into an 80-level 7-bit code.
// [R2] Device lowers gain above the drop level, raises below raise level.
// [R3] Limits reset to 30 and 70, settle count to 10.
// [R4] Limits must differ by more than 30; otherwise the word is refused.
// [R5] Offset clock divider 4, 8 or 16 chosen for 1 to 2 MHz.
// [R6] Gain loop on after power-up; gain word can switch it off.
// [R7] Settle count times sequencer divider over crystal must be 25 us or more.
// [R8] Device filters the level further in amplitude-keyed mode.
// [R9] Power in half dBm is level code plus correction minus 240.
// [R10] Readback carries lna and filter gain codes with the level.
// [R11] Gain correction: 0, 24, 45, 63, 90, 105 by gain pair.
// [R12] Demodulator select 01 picks the correlator.
// [R13] Device correlates limited IF at IF plus and minus deviation.
// [R14] Slicer filter cutoff setting is written as given by software.
// [R15] Device slices correlator output against zero.
// [R16] Frequency correction advised when error exceeds 40 percent of deviation.
// [R17] Recovery clock must be 32 times data rate, tolerating 2 percent.
// [R18] Correlator bandwidth is demod clock times K over 800 thousand, rounded.
// [R19] Parity bit is K odd; polarity bit follows parity of K or K+1 halves.
// [R20] Select 00 gives linear FSK, 10 gives amplitude keying.
// [R21] LNA gain is host writable and loop driven when loop enabled.
// [R22] Device steps the gain one state at a time.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module rgc_host #(
   parameter int SCLK_HALF = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             ser_clk,
   output logic             ser_data,
   output logic             ser_load,
   input  wire logic        ser_read_data,
   output logic             afc_advised
);
   // ----------------------------------------------------------------
   // Settings registers
   // ----------------------------------------------------------------
   logic [6:0]  raise_level_reg;
   logic [6:0]  drop_level_reg;
   logic [7:0]  settle_reg;
   logic [5:0]  xtal_mhz_reg;
   logic [15:0] seq_div_reg;
   logic [1:0]  demod_sel_reg;
   logic [9:0]  cutoff_reg;
   logic [15:0] demod_khz_reg;
   logic [7:0]  k_reg;
   logic        agc_on_reg;
   logic [1:0]  lna_gain_reg;
   logic [1:0]  filt_gain_reg;
   logic [15:0] err_khz_reg;
   logic [15:0] dev_khz_reg;
   logic [15:0] raw_reg;
   logic        done_reg;
   logic        refused_reg;

   logic setup;
   logic access;
   logic mapped;
   logic go;
   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;
   localparam logic [5:0] OFS_RAW_IDX = rgc_pkg::OFS_RAW[7:2];
   assign mapped = (paddr[7:2] <= OFS_RAW_IDX) && (paddr[1:0] == 2'h0);
   assign pslverr = access && !mapped;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         raise_level_reg <= rgc_pkg::RST_RAISE_LEVEL;   // [R3]
         drop_level_reg  <= rgc_pkg::RST_DROP_LEVEL;    // [R3]
         settle_reg      <= rgc_pkg::RST_SETTLE;        // [R3]
         xtal_mhz_reg    <= 6'h0A;
         seq_div_reg     <= 16'h0032;
         demod_sel_reg   <= rgc_pkg::DEMOD_CORR;
         cutoff_reg      <= 10'h009;
         demod_khz_reg   <= 16'h1388;
         k_reg           <= 8'h0A;
         agc_on_reg      <= 1'b1;                       // [R6]
         lna_gain_reg    <= 2'h3;
         filt_gain_reg   <= 2'h2;
         err_khz_reg     <= 16'h0000;
         dev_khz_reg     <= 16'h0000;
      end
      else if (access && pwrite)
      begin
         case (paddr)
            rgc_pkg::OFS_LIMITS:
            begin
               raise_level_reg <= pwdata[6:0];
               drop_level_reg  <= pwdata[14:8];
               settle_reg      <= pwdata[23:16];
            end
            rgc_pkg::OFS_CLOCKS:
            begin
               xtal_mhz_reg <= pwdata[5:0];
               seq_div_reg  <= pwdata[23:8];
            end
            rgc_pkg::OFS_DEMOD:
            begin
               demod_sel_reg <= pwdata[1:0];                   // [R12] [R20]
               cutoff_reg    <= pwdata[11:2];                  // [R14]
            end
            rgc_pkg::OFS_CORR:
            begin
               demod_khz_reg <= pwdata[15:0];
               k_reg         <= pwdata[23:16];
            end
            rgc_pkg::OFS_GAIN:
            begin
               agc_on_reg    <= pwdata[0];                     // [R6]
               lna_gain_reg  <= pwdata[2:1];                   // [R21]
               filt_gain_reg <= pwdata[4:3];
            end
            rgc_pkg::OFS_AFC:
            begin
               err_khz_reg <= pwdata[15:0];
               dev_khz_reg <= pwdata[31:16];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Derived settings and checks
   // ----------------------------------------------------------------
   logic [1:0]  offset_div_code;
   logic        offset_div_ok;
   logic        limits_ok;
   logic        wait_ok;
   logic [23:0] corr_bw_full;
   logic [9:0]  corr_bw;
   logic [8:0]  k_plus_one;
   logic        parity_bit;
   logic        polarity_bit;

   always_comb
   begin
      // Smallest divider giving 1 to 2 MHz
      offset_div_ok   = 1'b1;
      if (xtal_mhz_reg >= 6'h04 && xtal_mhz_reg <= 6'h08)
         offset_div_code = 2'h0;                               // [R5]
      else if (xtal_mhz_reg >= 6'h08 && xtal_mhz_reg <= 6'h10)
         offset_div_code = 2'h1;                               // [R5]
      else if (xtal_mhz_reg >= 6'h10 && xtal_mhz_reg <= 6'h20)
         offset_div_code = 2'h2;                               // [R5]
      else
      begin
         offset_div_code = 2'h0;
         offset_div_ok   = 1'b0;
      end
   end

   assign limits_ok = (drop_level_reg > raise_level_reg) &&
                      ((drop_level_reg - raise_level_reg) > rgc_pkg::MIN_LIMIT_GAP);   // [R4]
   assign wait_ok = ({8'h00, settle_reg} * {8'h00, seq_div_reg}) >=
                    (32'(rgc_pkg::MIN_WAIT_US) * {26'h0, xtal_mhz_reg});               // [R7]
   assign corr_bw_full = (demod_khz_reg * {8'h00, k_reg} + rgc_pkg::CORR_BW_ROUND) /
                         rgc_pkg::CORR_BW_DIV;                                         // [R18]
   assign corr_bw      = corr_bw_full[9:0];
   assign k_plus_one   = {1'b0, k_reg} + 9'h001;
   assign parity_bit   = k_reg[0];                                                     // [R19]
   assign polarity_bit = k_reg[0] ? k_plus_one[1] : k_reg[1];                          // [R19]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         afc_advised <= 1'b0;
      else
         afc_advised <= ({2'h0, err_khz_reg, 2'h0} + {4'h0, err_khz_reg}) >
                        {3'h0, dev_khz_reg, 1'b0};                                     // [R16]
   end

   // ----------------------------------------------------------------
   // Device word assembly
   // ----------------------------------------------------------------
   logic [2:0]  cmd_code;
   logic [31:0] word;
   logic        word_ok;
   assign go       = access && pwrite && (paddr == rgc_pkg::OFS_CTRL) && pwdata[3];
   assign cmd_code = pwdata[2:0];

   always_comb
   begin
      word    = 32'h0000_0000;
      word_ok = 1'b1;
      case (rgc_pkg::rgc_cmd_type'(cmd_code))
         rgc_pkg::CMD_OFFSET_CLK:
         begin
            word = {28'h0, rgc_pkg::DEV_ADDR_CLK};
            word[rgc_pkg::OFFSET_DIV_LSB +: 2] = offset_div_code;                       // [R5]
            word_ok = offset_div_ok;
         end
         rgc_pkg::CMD_DEMOD:
         begin
            word = {28'h0, rgc_pkg::DEV_ADDR_DEMOD};
            word[rgc_pkg::DEMOD_SEL_LSB +: 2] = demod_sel_reg;                          // [R12]
            word[rgc_pkg::POST_BW_LSB +: 10]  = cutoff_reg;                             // [R14]
         end
         rgc_pkg::CMD_CORR:
         begin
            word = {28'h0, rgc_pkg::DEV_ADDR_CORR};
            word[rgc_pkg::CORR_BW_LSB +: 10] = corr_bw;                                // [R18]
            word[rgc_pkg::PARITY_BIT]        = parity_bit;                             // [R19]
            word[rgc_pkg::POLARITY_BIT]      = polarity_bit;                           // [R19]
         end
         rgc_pkg::CMD_GAIN:
         begin
            word = {28'h0, rgc_pkg::DEV_ADDR_GAIN};
            word[rgc_pkg::AGC_OFF_BIT]         = !agc_on_reg;                          // [R6]
            word[rgc_pkg::LNA_GAIN_LSB +: 2]   = lna_gain_reg;                         // [R21]
            word[rgc_pkg::FILT_GAIN_LSB +: 2]  = filt_gain_reg;
         end
         rgc_pkg::CMD_LIMITS:
         begin
            word = {28'h0, rgc_pkg::DEV_ADDR_LIMITS};
            word[rgc_pkg::RAISE_LSB +: 7]  = raise_level_reg;                          // [R2]
            word[rgc_pkg::DROP_LSB +: 7]   = drop_level_reg;                           // [R2]
            word[rgc_pkg::SETTLE_LSB +: 8] = settle_reg;                               // [R7]
            word_ok = limits_ok && wait_ok;                                            // [R4] [R7]
         end
         rgc_pkg::CMD_READ:
            word = 32'h0000_0000;
         default:
            word_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LOAD, ST_READ} rgc_state_type;
   rgc_state_type state_reg;
   logic [31:0]   shift_reg;
   logic [5:0]    bits_reg;
   logic [7:0]    phase_reg;
   logic          is_read_reg;
   logic          half_end;
   logic          busy;
   assign half_end = (phase_reg == 8'(SCLK_HALF - 1));
   assign busy     = (state_reg != ST_IDLE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg   <= ST_IDLE;
         shift_reg   <= 32'h0000_0000;
         bits_reg    <= 6'h00;
         phase_reg   <= 8'h00;
         is_read_reg <= 1'b0;
         ser_clk     <= 1'b0;
         ser_data    <= 1'b0;
         ser_load    <= 1'b0;
         raw_reg     <= 16'h0000;
         done_reg    <= 1'b0;
         refused_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= (busy && !half_end) ? phase_reg + 8'h01 : 8'h00;
         case (state_reg)
            ST_IDLE:
            begin
               if (go && word_ok && !busy)
               begin
                  is_read_reg <= (cmd_code == 3'(rgc_pkg::CMD_READ));
                  shift_reg   <= {word[30:0], 1'b0};
                  ser_data    <= word[31];
                  bits_reg    <= 6'(rgc_pkg::WORD_BITS);
                  done_reg    <= 1'b0;
                  refused_reg <= 1'b0;
                  state_reg   <= (cmd_code == 3'(rgc_pkg::CMD_READ)) ? ST_LOAD : ST_SHIFT;
               end
               else if (go)
                  refused_reg <= 1'b1;
            end
            ST_SHIFT:
               if (half_end)
               begin
                  ser_clk <= !ser_clk;
                  if (ser_clk)
                  begin
                     if (bits_reg == 6'h01)
                        state_reg <= ST_LOAD;
                     else
                     begin
                        ser_data  <= shift_reg[31];
                        shift_reg <= {shift_reg[30:0], 1'b0};
                     end
                     bits_reg <= bits_reg - 6'h01;
                  end
               end
            ST_LOAD:
               if (half_end)
               begin
                  ser_load <= !ser_load;
                  ser_data <= 1'b0;
                  if (ser_load)
                  begin
                     bits_reg  <= 6'(rgc_pkg::READ_BITS);
                     state_reg <= is_read_reg ? ST_READ : ST_IDLE;
                     done_reg  <= !is_read_reg;
                  end
               end
            ST_READ:
               if (half_end)
               begin
                  ser_clk <= !ser_clk;
                  if (!ser_clk)
                     raw_reg <= {raw_reg[14:0], ser_read_data};                        // [R10]
                  else
                  begin
                     bits_reg <= bits_reg - 6'h01;
                     if (bits_reg == 6'h01)
                     begin
                        state_reg <= ST_IDLE;
                        done_reg  <= 1'b1;
                     end
                  end
               end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Level conversion
   // ----------------------------------------------------------------
   logic [6:0]        level_code;
   logic [1:0]        rb_lna;
   logic [1:0]        rb_filt;
   logic [6:0]        gain_corr;
   logic signed [15:0] power_x2;
   assign level_code = raw_reg[rgc_pkg::RB_LEVEL_LSB +: 7];                            // [R1] [R9]
   assign rb_lna     = raw_reg[rgc_pkg::RB_LNA_LSB +: 2];                              // [R10]
   assign rb_filt    = raw_reg[rgc_pkg::RB_FILT_LSB +: 2];                             // [R10]

   always_comb
   begin
      case ({rb_lna, rb_filt})
         4'b1110: gain_corr = 7'd0;                                                    // [R11]
         4'b1010: gain_corr = 7'd24;                                                   // [R11]
         4'b1001: gain_corr = 7'd45;                                                   // [R11]
         4'b1000: gain_corr = 7'd63;                                                   // [R11]
         4'b0100: gain_corr = 7'd90;                                                   // [R11]
         4'b0000: gain_corr = 7'd105;                                                  // [R11]
         default: gain_corr = 7'd0;
      endcase
   end
   assign power_x2 = rgc_pkg::POWER_BASE_X2 + $signed({9'h000, level_code}) +
                     $signed({9'h000, gain_corr});                                     // [R9]

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup && !pwrite)
      begin
         case (paddr)
            rgc_pkg::OFS_STATUS:
               prdata <= {26'h0, wait_ok, limits_ok, offset_div_ok, refused_reg,
                          done_reg, busy};
            rgc_pkg::OFS_LIMITS:
               prdata <= {8'h00, settle_reg, 1'b0, drop_level_reg, 1'b0, raise_level_reg};
            rgc_pkg::OFS_CLOCKS:
               prdata <= {8'h00, seq_div_reg, 2'h0, xtal_mhz_reg};
            rgc_pkg::OFS_DEMOD:
               prdata <= {20'h0, cutoff_reg, demod_sel_reg};
            rgc_pkg::OFS_CORR:
               prdata <= {polarity_bit, parity_bit, corr_bw[5:0], k_reg, demod_khz_reg};
            rgc_pkg::OFS_GAIN:
               prdata <= {27'h0, filt_gain_reg, lna_gain_reg, agc_on_reg};
            rgc_pkg::OFS_AFC:
               prdata <= {dev_khz_reg, err_khz_reg};
            rgc_pkg::OFS_LEVEL:
               prdata <= {power_x2, 4'h0, rb_filt, rb_lna, 1'b0, level_code};
            rgc_pkg::OFS_RAW:
               prdata <= {6'h00, corr_bw, raw_reg};
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : rgc_host

/* rgc_host_chk.sv */
// Port checker for the gain-loop host controller.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module rgc_host_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ser_clk,
   input wire logic        ser_data,
   input wire logic        ser_load,
   input wire logic        ser_read_data,
   input wire logic        afc_advised
);
   logic [31:0] bw;
   logic [7:0]  k1;
   logic [7:0]  gc;
   logic [3:0]  gp;
   logic        afc_wr;
   logic        afc_exp;
   assign bw = (prdata[15:0] * prdata[23:16] + 32'h190) / 32'h320;
   assign k1 = prdata[23:16] + 8'h01;
   assign gp = {prdata[9:8], prdata[11:10]};
   assign gc = (gp == 4'hE) ? 8'h00 : (gp == 4'hA) ? 8'h18 : (gp == 4'h9) ? 8'h2D :
               (gp == 4'h8) ? 8'h3F : (gp == 4'h4) ? 8'h5A : (gp == 4'h0) ? 8'h69 : 8'h00;
   assign afc_wr = psel && penable && pwrite && paddr == rgc_pkg::OFS_AFC;
   assign afc_exp = 32'(pwdata[15:0]) * 5 > 32'(pwdata[31:16]) * 2;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_read(a);
      psel && penable && !pwrite && paddr == a;
   endsequence
   sequence s_afc_write;
      afc_wr ##1 !afc_wr;
   endsequence
   property p_ready; psel && penable |-> pready; endproperty
   property p_err; pslverr |-> psel && penable; endproperty
   property p_ser; ser_clk && $past(ser_clk) |-> $stable(ser_data); endproperty
   property p_load; ser_load |-> !ser_clk; endproperty
   property p_level;
      s_read(rgc_pkg::OFS_LEVEL) |-> prdata[31:16] == 16'(prdata[6:0]) + 16'(gc) - 16'h00F0;
   endproperty
   property p_bw; s_read(rgc_pkg::OFS_CORR) |-> prdata[29:24] == bw[5:0]; endproperty
   property p_parity;
      s_read(rgc_pkg::OFS_CORR) |-> prdata[30] == prdata[16] && prdata[31] == k1[1];
   endproperty
   property p_afc; s_afc_write |=> afc_advised == $past(afc_exp, 2); endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   a_err: assert property (p_err) else $error("pslverr outside access");
   a_ser: assert property (p_ser) else $error("serial data moved while clock high");
   a_load: assert property (p_load) else $error("load strobe with clock high");
   a_level: assert property (p_level) else $error("power value wrong");
   a_bw: assert property (p_bw) else $error("correlator bandwidth wrong");
   a_parity: assert property (p_parity) else $error("parity or polarity wrong");
   a_afc: assert property (p_afc) else $error("correction advice wrong");
endmodule : rgc_host_chk
bind rgc_host rgc_host_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load),
   .ser_read_data(ser_read_data), .afc_advised(afc_advised));

/* rgc_pkg.sv */
// Constants for the receiver gain-loop and correlator host controller.
// Assumes a 32-bit APB bus and the device's three-wire serial port.
package rgc_pkg;
   // ----------------------------------------------------------------
   // APB register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_LIMITS  = 8'h08;
   localparam logic [7:0] OFS_CLOCKS  = 8'h0C;
   localparam logic [7:0] OFS_DEMOD   = 8'h10;
   localparam logic [7:0] OFS_CORR    = 8'h14;
   localparam logic [7:0] OFS_GAIN    = 8'h18;
   localparam logic [7:0] OFS_AFC     = 8'h1C;
   localparam logic [7:0] OFS_LEVEL   = 8'h20;
   localparam logic [7:0] OFS_RAW     = 8'h24;
   // ----------------------------------------------------------------
   // Reset values and check limits
   // ----------------------------------------------------------------
   localparam logic [6:0] RST_RAISE_LEVEL = 7'h1E;   // 30
   localparam logic [6:0] RST_DROP_LEVEL  = 7'h46;   // 70
   localparam logic [7:0] RST_SETTLE      = 8'h0A;   // 10
   localparam logic [6:0] MIN_LIMIT_GAP   = 7'h1E;   // 30
   localparam int         MIN_WAIT_US     = 25;
   // ----------------------------------------------------------------
   // Commands and demodulator modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_OFFSET_CLK, CMD_DEMOD, CMD_CORR, CMD_GAIN, CMD_LIMITS, CMD_READ
   } rgc_cmd_type;
   localparam logic [1:0] DEMOD_LINEAR = 2'h0;
   localparam logic [1:0] DEMOD_CORR   = 2'h1;
   localparam logic [1:0] DEMOD_ASK    = 2'h2;
   // ----------------------------------------------------------------
   // Device word layout
   // ----------------------------------------------------------------
   localparam logic [3:0] DEV_ADDR_CLK    = 4'h3;
   localparam logic [3:0] DEV_ADDR_DEMOD  = 4'h4;
   localparam logic [3:0] DEV_ADDR_CORR   = 4'h6;
   localparam logic [3:0] DEV_ADDR_GAIN   = 4'h9;
   localparam logic [3:0] DEV_ADDR_LIMITS = 4'hA;
   localparam int OFFSET_DIV_LSB  = 4;
   localparam int DEMOD_SEL_LSB   = 4;
   localparam int POST_BW_LSB     = 6;
   localparam int CORR_BW_LSB     = 4;
   localparam int PARITY_BIT      = 14;
   localparam int POLARITY_BIT    = 29;
   localparam int AGC_OFF_BIT     = 19;
   localparam int LNA_GAIN_LSB    = 20;
   localparam int FILT_GAIN_LSB   = 22;
   localparam int RAISE_LSB       = 4;
   localparam int DROP_LSB        = 11;
   localparam int SETTLE_LSB      = 18;
   localparam int WORD_BITS       = 32;
   localparam int READ_BITS       = 16;
   // Readback: level in bits 7..1, filter gain 9..8, lna gain 11..10
   localparam int RB_LEVEL_LSB    = 1;
   localparam int RB_FILT_LSB     = 8;
   localparam int RB_LNA_LSB      = 10;
   // ----------------------------------------------------------------
   // Level conversion and correlator bandwidth
   // ----------------------------------------------------------------
   localparam logic signed [15:0] POWER_BASE_X2 = -16'sd240;   // -120 dBm
   localparam logic [23:0] CORR_BW_DIV   = 24'd800;
   localparam logic [23:0] CORR_BW_ROUND = 24'd400;
endpackage : rgc_pkg

/* tb.sv */
// Bench for rgc_host: APB tasks issue commands, a device model answers.
// Assumes rgc_dev_model on the serial port and the bound checker.
`timescale 1ns/10ps
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, ser_clk, ser_data, ser_load, ser_rd, afc_advised, err, pol;
   logic [7:0]  paddr = 8'h00, ks[4] = '{8'h0A, 8'h09, 8'h0B, 8'h0C};
   logic [7:0]  ls[3] = '{8'h05, 8'h05, 8'h04};
   logic [31:0] pwdata = 32'h0, prdata, word, rd, st;
   logic [6:0]  level = 7'h00, ld[3] = '{7'h33, 7'h32, 7'h33}, lv[3] = '{7'h32, 7'h4F, 7'h00};
   logic [5:0]  xt[4] = '{6'h04, 6'h20, 6'h28, 6'h0A};
   logic [1:0]  oc[4] = '{2'h0, 2'h2, 2'h2, 2'h1}, gl[3] = '{2'h2, 2'h0, 2'h3};
   logic [1:0]  gf[3] = '{2'h1, 2'h0, 2'h2};
   logic        lb[3] = '{1'b0, 1'b1, 1'b1}, ob[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   int          errors = 0, tests_run = 0, bw, gc[3] = '{45, 105, 0};
   always #2.5 pclk = ~pclk;
   rgc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load), .ser_read_data(ser_rd),
      .afc_advised(afc_advised));
   rgc_dev_model dev (.ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load),
      .level(level), .ser_read_data(ser_rd), .word(word));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic cmd(input logic [2:0] c);
      apb(1'b1, 8'h00, {28'h0, 1'b1, c});
      rd = 32'h1;
      while (rd[0] !== 1'b0)
         apb(1'b0, 8'h04, 32'h0);
      st = rd;
   endtask : cmd
   task automatic tally_and_finish;
      $display("errors %0d, tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #200us;
      errors++;
      tally_and_finish;
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h000A461E);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h00000017);
      apb(1'b0, 8'h30, 32'h0);
      chk({rd[31:1], err}, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, 8'h0C, {8'h00, 16'h0032, 2'h0, xt[i]});
         cmd(3'h0);
         chk({st[2], ob[i] ? {oc[i], 4'h3} : word[5:0]}, {ob[i], oc[i], 4'h3});
         bw = (5000 * ks[i] + 400) / 800;
         pol = ks[i][1] ^ ks[i][0];
         apb(1'b1, 8'h14, {8'h00, ks[i], 16'h1388});
         apb(1'b0, 8'h14, 32'h0);
         chk(rd, {pol, ks[i][0], 6'(bw), ks[i], 16'h1388});
         cmd(3'h2);
         chk({word[29], word[14:0]}, {pol, ks[i][0], 10'(bw), 4'h6});
      end
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, 8'h08, {8'h00, ls[i], 1'b0, ld[i], 8'h14});
         cmd(3'h4);
         chk({st[2], lb[i] ? 31'h0015994A : word[30:0]}, {lb[i], 31'h0015994A});
         apb(1'b1, 8'h10, {20'h0, 10'h009, 2'(i)});
         cmd(3'h1);
         chk(word[15:0], {10'h009, 2'(i), 4'h4});
         apb(1'b1, 8'h18, {27'h0, gf[i], gl[i], 1'b0});
         cmd(3'h3);
         chk(word & 32'h00F8000F, {8'h00, gf[i], gl[i], 1'b1, 15'h0, 4'h9});
         level <= lv[i];
         cmd(3'h5);
         apb(1'b0, 8'h20, 32'h0);
         chk(rd, {16'(lv[i] + gc[i] - 240), 4'h0, gf[i], gl[i], 1'b0, lv[i]});
      end
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, 8'h1C, {16'h000C, 16'(5 - i)});
         @(posedge pclk);
         chk({31'h0, afc_advised}, 32'(1 - i));
      end
      tally_and_finish;
   end
endmodule : tb
